/* File: design/tmz_pkg.sv */
// constants, field layouts and carrier types for the timer block
package tmz_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [9:0] IDX_TIMER = 10'h001;
  localparam logic [9:0] IDX_INTCTL = 10'h00b;
  localparam logic [9:0] IDX_OPTION = 10'h081;
  localparam logic [9:0] IDX_CTRL = 10'h0c0;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  // reset values and the count maximum
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [7:0] INTCTL_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  // interrupt control bit positions
  localparam int INT_FLAG_BIT = 2;
  localparam int INT_EN_BIT = 5;
  // block control register bit positions
  localparam int CTRL_SLEEP_BIT = 0;
  localparam int CTRL_WDCLR_BIT = 1;
  localparam int CTRL_BUSY_BIT = 2;
  // increments suppressed for this many instruction cycles after a count write
  localparam logic [1:0] INH_CYCLES = 2'h2;
  // phase clocks per instruction cycle
  localparam int PHASES_PER_INST = 4;

  // option register layout, msb first
  typedef struct packed {
    logic pullup_off;
    logic int_edge;
    logic clock_source_select;
    logic source_edge_select;
    logic prescaler_assignment;
    logic [2:0] prescale_ratio_field;
  } tmz_option_t;

  // apb request group
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } tmz_apb_req_t;
endpackage : tmz_pkg

/* File: design/tmz_timer0.sv */
// 8-bit timer/counter with shared prescaler, apb register slave
`timescale 1ns/1ns

// Notes on behaviour
// RULE1 - eight-bit count, readable and writable by software
// RULE2 - timer mode without prescaler: one increment per instruction cycle
// RULE3 - after a count write, increments held off for two instruction cycles
// RULE4 - counter mode counts edges of the external count pin
// RULE5 - edge select: cleared counts rising edges, set counts falling edges
// RULE6 - external pin synchronised first; increment follows after the sync delay
// RULE7 - one eight-bit prescaler, owned by timer or watchdog, never both
// RULE8 - prescaler count has no software read or write path
// RULE9 - option bits three..zero: assignment bit over three ratio bits
// RULE10 - timer-owned prescaler divides by two up to two hundred fifty-six
// RULE11 - watchdog-owned prescaler divides by one up to one hundred twenty-eight
// RULE12 - timer owned: count write zeroes prescaler, option untouched
// RULE13 - watchdog owned: watchdog clear zeroes prescaler and watchdog count
// RULE14 - software uses a guarded sequence when moving prescaler to watchdog
// RULE15 - rollover from maximum to zero sets the overflow flag
// RULE16 - overflow request raised only while overflow enable is set
// RULE17 - hardware never clears the flag; software clears it
// RULE18 - counter stops in sleep, so overflow cannot wake the core
// RULE19 - reset: option all ones, interrupt control cleared
// RULE20 - watchdog owned: source events drive the counter directly
module tmz_timer0 #(
  parameter int PHASES = tmz_pkg::PHASES_PER_INST
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire tmz_pkg::tmz_apb_req_t apb_req,
  output logic [tmz_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_count_pin,
  input wire logic watchdog_tick,
  output logic watchdog_postscaled,
  output logic watchdog_clear,
  output logic overflow_req
);
  import tmz_pkg::*;

  localparam int PH_W = (PHASES > 1) ? $clog2(PHASES) : 1;
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(PHASES - 1);
  // worst case from a count write to the end of hold-off, in clocks
  localparam int HOLD_MAX = 2 * PHASES + 1;

  logic [7:0] count_r;
  logic [7:0] intctl_r;
  tmz_option_t option_r;
  logic [7:0] pre_cnt_r;
  logic [1:0] inh_r;
  logic [PH_W-1:0] phase_r;
  logic sleep_r;
  logic wdclr_r;
  logic wdog_out_r;
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_s3_r;
  logic [DATA_W-1:0] rdata_r;

  logic access;
  logic wr;
  logic [9:0] idx;
  logic hit;
  logic wr_timer;
  logic wr_intctl;
  logic wr_option;
  logic wr_ctrl;
  logic wd_clr_cmd;
  logic inst_tick;
  logic ext_evt;
  logic src_evt;
  logic pre_clr;
  logic pre_adv;
  logic [7:0] tmr_mask;
  logic [7:0] wdt_mask;
  logic tmr_hit;
  logic wdt_hit;
  logic tmr_evt;
  logic tmr_inc;
  logic ovf_set;
  logic [7:0] rd_mux;

  // apb decode; zero wait states, unmapped index answers with pslverr
  assign access = apb_req.psel & apb_req.penable;
  assign wr = access & apb_req.pwrite;
  assign idx = apb_req.paddr[ADDR_W-1:2];
  assign hit = (idx == IDX_TIMER) | (idx == IDX_INTCTL) |
               (idx == IDX_OPTION) | (idx == IDX_CTRL);
  assign wr_timer = wr & (idx == IDX_TIMER);
  assign wr_intctl = wr & (idx == IDX_INTCTL);
  assign wr_option = wr & (idx == IDX_OPTION);
  assign wr_ctrl = wr & (idx == IDX_CTRL);
  assign wd_clr_cmd = wr_ctrl & apb_req.pwdata[CTRL_WDCLR_BIT];
  assign pready = 1'b1;
  assign pslverr = access & ~hit;

  // read mux; prescaler count deliberately absent
  always_comb begin
    rd_mux = 8'h00;
    case (idx)
      IDX_TIMER: rd_mux = count_r;
      IDX_INTCTL: rd_mux = intctl_r;
      IDX_OPTION: rd_mux = option_r;
      IDX_CTRL: begin
        rd_mux[CTRL_SLEEP_BIT] = sleep_r;
        rd_mux[CTRL_BUSY_BIT] = (inh_r != 2'h0);
      end
      default: rd_mux = 8'h00;
    endcase
  end // RULE8

  // read data captured in the setup phase, held through access
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 32'h0000_0000;
    end else if (apb_req.psel && !apb_req.penable) begin
      rdata_r <= {24'h00_0000, rd_mux};
    end
  end
  assign prdata = rdata_r;

  // instruction cycle strobe from the phase clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= '0;
    end else if (phase_r == PH_LAST) begin
      phase_r <= '0;
    end else begin
      phase_r <= phase_r + PH_W'(1);
    end
  end
  assign inst_tick = (phase_r == PH_LAST);

  // pin synchroniser; the second and third stages feed the edge detect
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= external_count_pin; // RULE6
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  // counting edge chosen by the edge select bit
  assign ext_evt = option_r.source_edge_select ? (ext_s3_r & ~ext_s2_r)
                                               : (ext_s2_r & ~ext_s3_r); // RULE5
  assign src_evt = option_r.clock_source_select ? ext_evt : inst_tick; // RULE2 RULE4

  // shared prescaler: owner picks who advances and who clears it
  assign pre_clr = option_r.prescaler_assignment ? wd_clr_cmd : wr_timer; // RULE12 RULE13
  assign pre_adv = option_r.prescaler_assignment ? watchdog_tick
                                                 : (src_evt & ~sleep_r); // RULE7
  assign tmr_mask = 8'((9'h002 << option_r.prescale_ratio_field) - 9'h001); // RULE10
  assign wdt_mask = 8'((9'h001 << option_r.prescale_ratio_field) - 9'h001); // RULE11
  assign tmr_hit = &(pre_cnt_r | ~tmr_mask);
  assign wdt_hit = &(pre_cnt_r | ~wdt_mask);

  // prescaler count; no bus path reaches it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_cnt_r <= 8'h00;
    end else if (pre_clr) begin
      pre_cnt_r <= 8'h00;
    end else if (pre_adv) begin
      pre_cnt_r <= pre_cnt_r + 8'h01; // RULE7 RULE9
    end
  end

  // watchdog side: postscaled tick and clear strobe, both registered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdog_out_r <= 1'b0;
      wdclr_r <= 1'b0;
    end else begin
      wdog_out_r <= option_r.prescaler_assignment
                    ? (watchdog_tick & wdt_hit & ~pre_clr) : watchdog_tick; // RULE11
      wdclr_r <= wd_clr_cmd; // RULE13
    end
  end
  assign watchdog_postscaled = wdog_out_r;
  assign watchdog_clear = wdclr_r;

  // direct source when watchdog owns the prescaler, else divided
  assign tmr_evt = option_r.prescaler_assignment ? src_evt
                                                 : (src_evt & tmr_hit); // RULE20 RULE10
  // stopped in sleep and during the post-write hold-off
  assign tmr_inc = tmr_evt & ~sleep_r & (inh_r == 2'h0) & ~wr_timer; // RULE3 RULE18
  assign ovf_set = tmr_inc & (count_r == COUNT_MAX);

  // hold-off counts whole instruction cycles, so a mid-cycle write loses
  // part of one; software compensates with an adjusted value
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      inh_r <= 2'h0;
    end else if (wr_timer) begin
      inh_r <= INH_CYCLES; // RULE3
    end else if (inst_tick && inh_r != 2'h0) begin
      inh_r <= inh_r - 2'h1;
    end
  end

  // the count itself
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= COUNT_RST;
    end else if (wr_timer) begin
      count_r <= apb_req.pwdata[REG_W-1:0]; // RULE1
    end else if (tmr_inc) begin
      count_r <= count_r + 8'h01;
    end
  end

  // option register; prescaler moves are software's care
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      option_r <= OPTION_RST; // RULE19
    end else if (wr_option) begin
      option_r <= apb_req.pwdata[REG_W-1:0]; // RULE9 RULE14
    end
  end

  // interrupt control: hardware only sets the flag, set beats a clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      intctl_r <= INTCTL_RST; // RULE19
    end else if (wr_intctl) begin
      intctl_r <= apb_req.pwdata[REG_W-1:0];
      if (ovf_set) begin
        intctl_r[INT_FLAG_BIT] <= 1'b1; // RULE15
      end
    end else if (ovf_set) begin
      intctl_r[INT_FLAG_BIT] <= 1'b1; // RULE15 RULE17
    end
  end
  assign overflow_req = intctl_r[INT_FLAG_BIT] & intctl_r[INT_EN_BIT]; // RULE16

  // sleep request bit, software set and cleared
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sleep_r <= 1'b0;
    end else if (wr_ctrl) begin
      sleep_r <= apb_req.pwdata[CTRL_SLEEP_BIT]; // RULE18
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence count_write_s;
    wr_timer;
  endsequence

  sequence holdoff_s;
    (inh_r != 2'h0);
  endsequence

  sequence holdoff_done_s;
    (inh_r == 2'h0) || wr_timer;
  endsequence

  count_write_a: assert property ( // RULE1
    count_write_s |=> count_r == $past(apb_req.pwdata[REG_W-1:0]))
    else $error("count write not stored");

  holdoff_arm_a: assert property ( // RULE3
    count_write_s |=> holdoff_s)
    else $error("hold-off not armed after count write");

  holdoff_hold_a: assert property ( // RULE3
    holdoff_s and !wr_timer |=> $stable(count_r))
    else $error("count moved during hold-off");

  timer_direct_a: assert property ( // RULE2
    !option_r.clock_source_select && option_r.prescaler_assignment && inst_tick
    && !sleep_r && inh_r == 2'h0 && !wr_timer |=> count_r == $past(count_r) + 8'h01)
    else $error("timer mode missed an instruction cycle");

  ext_direct_a: assert property ( // RULE4
    option_r.clock_source_select && option_r.prescaler_assignment && ext_evt
    && !sleep_r && inh_r == 2'h0 && !wr_timer |=> count_r == $past(count_r) + 8'h01)
    else $error("counter mode missed a pin edge");

  ext_rise_a: assert property ( // RULE5
    ext_evt && !option_r.source_edge_select
    |-> $past(external_count_pin, 2) && !$past(external_count_pin, 3))
    else $error("rising edge event without rising pin");

  ext_fall_a: assert property ( // RULE6
    ext_evt && option_r.source_edge_select
    |-> !$past(external_count_pin, 2) && $past(external_count_pin, 3))
    else $error("falling edge event without falling pin");

  pre_divide_a: assert property ( // RULE10
    tmr_inc && !option_r.prescaler_assignment |-> pre_cnt_r[0])
    else $error("prescaled increment before two source events");

  pre_owner_a: assert property ( // RULE7
    !option_r.prescaler_assignment && !wdog_out_r ##1 watchdog_tick
    |=> watchdog_postscaled)
    else $error("watchdog tick not passed through");

  pre_tclear_a: assert property ( // RULE12
    wr_timer && !option_r.prescaler_assignment
    |=> pre_cnt_r == 8'h00 && $stable(option_r))
    else $error("count write did not clear prescaler");

  pre_wclear_a: assert property ( // RULE13
    wd_clr_cmd && option_r.prescaler_assignment |=> pre_cnt_r == 8'h00 && watchdog_clear)
    else $error("watchdog clear did not clear prescaler");

  ovf_flag_a: assert property ( // RULE15
    ovf_set |=> intctl_r[INT_FLAG_BIT])
    else $error("rollover did not set flag");

  ovf_mask_a: assert property ( // RULE16
    overflow_req |-> intctl_r[INT_EN_BIT] && intctl_r[INT_FLAG_BIT])
    else $error("request raised while masked");

  flag_sticky_a: assert property ( // RULE17
    intctl_r[INT_FLAG_BIT] && !wr_intctl |=> intctl_r[INT_FLAG_BIT])
    else $error("flag cleared by hardware");

  sleep_stop_a: assert property ( // RULE18
    sleep_r && !wr_timer |=> $stable(count_r))
    else $error("counter ran in sleep");

  // a new write may re-arm the hold-off, which also counts as done here
  holdoff_end_a: assert property ( // RULE3
    count_write_s |-> ##[1:HOLD_MAX] holdoff_done_s)
    else $error("hold-off outlasted two instruction cycles");

  // no source event, no movement; catches a wrong source leaking in
  timer_gate_a: assert property ( // RULE2
    !option_r.clock_source_select && !inst_tick && !wr_timer |=> $stable(count_r))
    else $error("timer mode counted without an instruction cycle");

  counter_gate_a: assert property ( // RULE4
    option_r.clock_source_select && !ext_evt && !wr_timer |=> $stable(count_r))
    else $error("counter mode counted without a pin edge");

  pre_wd_idle_a: assert property ( // RULE7
    option_r.prescaler_assignment && !watchdog_tick && !wd_clr_cmd |=> $stable(pre_cnt_r))
    else $error("timer events reached the watchdog-owned prescaler");

  pre_sleep_a: assert property ( // RULE18
    !option_r.prescaler_assignment && sleep_r && !wr_timer |=> $stable(pre_cnt_r))
    else $error("timer-owned prescaler ran in sleep");

  wdog_mask_a: assert property ( // RULE11
    option_r.prescaler_assignment && !(watchdog_tick && wdt_hit) |=> !watchdog_postscaled)
    else $error("watchdog tick passed before the ratio was reached");

  wdclr_pulse_a: assert property ( // RULE13
    watchdog_clear |=> !watchdog_clear)
    else $error("watchdog clear longer than one cycle");

  flag_source_a: assert property ( // RULE15
    !intctl_r[INT_FLAG_BIT] && !wr_intctl && !(tmr_inc && count_r == COUNT_MAX)
    |=> !intctl_r[INT_FLAG_BIT])
    else $error("flag set without a rollover");

  timer_read_a: assert property ( // RULE1
    apb_req.psel && !apb_req.penable && !apb_req.pwrite && idx == IDX_TIMER
    |=> prdata[REG_W-1:0] == $past(count_r))
    else $error("count read returned a stale value");

  // unmapped reads must not leak any internal count, the prescaler included
  err_read_a: assert property ( // RULE8
    pslverr |-> prdata == '0)
    else $error("unmapped read returned data");
endmodule : tmz_timer0

/* File: test/tmz_count_src.sv */
// behavioural source driving the external count pin
`timescale 1ns/1ns
module tmz_count_src (
  input wire logic clk,
  output logic pin
);
  initial pin = 1'h0;
  // each level held three clocks so the synchroniser never misses it
  task automatic toggle(input int n);
    repeat (n) begin
      pin <= ~pin;
      repeat (3) @(posedge clk);
    end
  endtask : toggle
endmodule : tmz_count_src

/* File: test/tb.sv */
// self-checking bench for the timer block
`timescale 1ns/1ns
module tb;
  import tmz_pkg::*;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  tmz_apb_req_t req = '0;
  logic [31:0] prdata;
  logic pready, pslverr, wd_post, wd_clr, ovf, pin, er;
  logic wd_tick = 1'h0;
  logic [31:0] rd;
  int fail_count = 0;
  int samples_checked = 0;
  int post_n = 0, clr_n = 0, cyc = 0, p;

  tmz_timer0 uut (.clk(clk), .rst_b(rst_b), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_count_pin(pin),
    .watchdog_tick(wd_tick), .watchdog_postscaled(wd_post),
    .watchdog_clear(wd_clr), .overflow_req(ovf));
  tmz_count_src src (.clk(clk), .pin(pin));

  // free-running core clock
  initial begin
    forever #2 clk = ~clk;
  end

  // pulse tallies and a guard against hangs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wd_post === 1'h1) post_n <= post_n + 1;
    if (wd_clr === 1'h1) clr_n <= clr_n + 1;
    if (cyc == 40000) begin
      fail_count++;
      summarize();
    end
  end

  task summarize();
    if (fail_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
    @(posedge clk);
    req <= {1'h1, 1'h0, w, i, 2'h0, 24'h00_0000, d};
    @(posedge clk);
    req.penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    req.psel <= 1'h0;
    req.penable <= 1'h0;
  endtask : apb

  task wr(input logic [9:0] i, input logic [7:0] d);
    apb(1'h1, i, d);
  endtask : wr

  task rdc(input logic [9:0] i, input logic [7:0] e);
    apb(1'h0, i, 8'h00);
    chk(rd, {24'h00_0000, e});
  endtask : rdc

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      wd_tick <= 1'h1;
      @(posedge clk);
      wd_tick <= 1'h0;
    end
  endtask : ticks

  task t_reset();
    rdc(IDX_OPTION, 8'hff);
    rdc(IDX_INTCTL, 8'h00);
    rdc(IDX_TIMER, 8'h00);
    wr(IDX_TIMER, 8'h5a);
    rdc(IDX_TIMER, 8'h5a);
    apb(1'h0, 10'h3ff, 8'h00);
    chk({rd[31:1], er}, 32'h0000_0001);
  endtask : t_reset

  // direct counting: odd edge count tells the two polarities apart
  task t_edge();
    for (int s = 0; s < 2; s++) begin
      wr(IDX_OPTION, s ? 8'h38 : 8'h28);
      wr(IDX_TIMER, 8'h00);
      repeat (10) @(posedge clk);
      src.toggle(5);
      repeat (8) @(posedge clk);
      rdc(IDX_TIMER, s ? 8'h02 : 8'h03);
      src.toggle(1);
      repeat (8) @(posedge clk);
    end
  endtask : t_edge

  // leftover edges before the write would add one count if not cleared
  task t_presc();
    for (int r = 0; r < 8; r++) begin
      p = 2 ** (r + 1);
      wr(IDX_OPTION, {5'h04, r[2:0]});
      src.toggle(2 * p - 2);
      repeat (6) @(posedge clk);
      wr(IDX_TIMER, 8'h00);
      repeat (10) @(posedge clk);
      src.toggle(6 * p + 2);
      repeat (8) @(posedge clk);
      rdc(IDX_TIMER, 8'h03);
      rdc(IDX_OPTION, {5'h04, r[2:0]});
    end
  endtask : t_presc

  // read sampled a whole number of instruction cycles after the write, so
  // the tick phase drops out: twenty cycles less two held off
  task t_timer();
    wr(IDX_CTRL, 8'h02);
    wr(IDX_OPTION, 8'h08);
    wr(IDX_TIMER, 8'h10);
    repeat (79) @(posedge clk);
    rdc(IDX_TIMER, 8'h22);
  endtask : t_timer

  task t_ovf();
    wr(IDX_INTCTL, 8'h00);
    wr(IDX_TIMER, 8'hfd);
    repeat (40) @(posedge clk);
    rdc(IDX_INTCTL, 8'h04);
    chk({31'h0, ovf}, 32'h0);
    wr(IDX_INTCTL, 8'h24);
    repeat (2) @(posedge clk);
    chk({31'h0, ovf}, 32'h1);
    repeat (60) @(posedge clk);
    rdc(IDX_INTCTL, 8'h24);
    wr(IDX_INTCTL, 8'h20);
    rdc(IDX_INTCTL, 8'h20);
    chk({31'h0, ovf}, 32'h0);
  endtask : t_ovf

  // timer-owned prescaler here, so the later move to the watchdog is real
  task t_sleep();
    wr(IDX_OPTION, 8'h00);
    wr(IDX_CTRL, 8'h01);
    wr(IDX_TIMER, 8'h10);
    rdc(IDX_CTRL, 8'h05);
    repeat (100) @(posedge clk);
    rdc(IDX_TIMER, 8'h10);
    rdc(IDX_CTRL, 8'h01);
    wr(IDX_CTRL, 8'h00);
    repeat (60) @(posedge clk);
    apb(1'h0, IDX_TIMER, 8'h00);
    chk({31'h0, rd[7:0] > 8'h10}, 32'h1);
  endtask : t_sleep

  // partial postscale count before the clear would add one pulse
  task t_wdog();
    wr(IDX_CTRL, 8'h02);
    for (int r = 0; r < 8; r++) begin
      p = 2 ** (r + 1) + 1;
      wr(IDX_OPTION, {5'h01, r[2:0]});
      ticks(2 ** r - 1);
      clr_n = 0;
      wr(IDX_CTRL, 8'h02);
      repeat (3) @(posedge clk);
      post_n = 0;
      ticks(p);
      repeat (3) @(posedge clk);
      chk(32'(post_n), 32'(p >> r));
      chk(32'(clr_n), 32'h1);
    end
    wr(IDX_OPTION, 8'h00);
    post_n = 0;
    ticks(3);
    repeat (3) @(posedge clk);
    chk(32'(post_n), 32'h3);
  endtask : t_wdog

  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'h1;
    t_reset();
    t_edge();
    t_presc();
    t_timer();
    t_ovf();
    t_sleep();
    t_wdog();
    summarize();
  end
endmodule : tb
